// >>> mhf_pkg.sv
// Purpose: shared constants for the multicast hash filter register bank
// Assumes: APB with 32-bit data, byte addresses
// Notes:   station address reset values are parameters of the top module
package mhf_pkg;
    localparam int unsigned           DATA_W          = 32;
    localparam int unsigned           ADDR_W          = 8;
    localparam logic [ADDR_W-1:0]     OFS_STATION_LOW = 8'ha4;
    localparam logic [ADDR_W-1:0]     OFS_STATION_HI  = 8'ha8;
    localparam logic [ADDR_W-1:0]     OFS_HASH_LOW    = 8'hac;
    localparam logic [ADDR_W-1:0]     OFS_HASH_HIGH   = 8'hb0;
    localparam logic [ADDR_W-1:0]     OFS_RX_STATE    = 8'hb4;
    localparam logic [DATA_W-1:0]     HASH_RESET      = 32'h00000000;
    localparam logic [2:0]            RX_STOPPED      = 3'h0;
    localparam int unsigned           RX_STATE_LSB    = 17;
    localparam int unsigned           STATION_HI_W    = 16;
endpackage

// >>> mhf_sync.sv
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second
module mhf_sync #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// >>> mhf_regs.sv
// Purpose: APB register bank: multicast hash table and station address
// Assumes: receive state arrives from another domain, synchronised here
// Notes:   zero-wait APB slave, unmapped reads return zero with pslverr
// ============================================================
// Summary of operation
// - hash bits 31:0 in low register
// - hash bits 63:32 in high register
// - hash registers read/write, reset zero
// - station address writable only when receive stopped
// - high station register: bytes five, four
module mhf_regs #(
    parameter logic [31:0] STATION_LOW_RESET = 32'h00000000,
    parameter logic [15:0] STATION_HI_RESET  = 16'h0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  rx_state,
    output logic      [63:0] hash_table,
    output logic      [47:0] station_addr,
    output logic             station_write_lock
);
    // ============================================================
    // receive state crossing
    logic [2:0]  rx_state_sync;
    logic        rx_stopped;

    mhf_sync #(.WIDTH(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (rx_state),
        .q       (rx_state_sync)
    );

    assign rx_stopped         = (rx_state_sync == mhf_pkg::RX_STOPPED);
    assign station_write_lock = !rx_stopped;

    // ============================================================
    // bus decode
    logic        wr_en;
    logic        rd_en;
    logic        rd_setup;
    logic        hit_hlo;
    logic        hit_hhi;
    logic        hit_slo;
    logic        hit_shi;
    logic        hit_rxs;
    logic        mapped;
    logic [3:0]  lane_wr;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign hit_hlo = (paddr == mhf_pkg::OFS_HASH_LOW);
    assign hit_hhi = (paddr == mhf_pkg::OFS_HASH_HIGH);
    assign hit_slo = (paddr == mhf_pkg::OFS_STATION_LOW);
    assign hit_shi = (paddr == mhf_pkg::OFS_STATION_HI);
    assign hit_rxs = (paddr == mhf_pkg::OFS_RX_STATE);
    assign mapped  = hit_hlo || hit_hhi || hit_slo || hit_shi || hit_rxs;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // one write strobe per byte lane
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign lane_wr[g] = wr_en && pstrb[g];
    end

    // ============================================================
    // storage
    localparam int STATION_LANES = mhf_pkg::STATION_HI_W / 8;
    logic [31:0] hash_low_reg;
    logic [31:0] hash_low_next;
    logic [31:0] hash_high_reg;
    logic [31:0] hash_high_next;
    logic [31:0] station_low_reg;
    logic [31:0] station_low_next;
    logic [15:0] station_hi_reg;
    logic [15:0] station_hi_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    always_comb begin
        hash_low_next    = hash_low_reg;
        hash_high_next   = hash_high_reg;
        station_low_next = station_low_reg;
        station_hi_next  = station_hi_reg;
        for (int b = 0; b < 4; b++) begin
            if (lane_wr[b] && hit_hlo) begin
                hash_low_next[b*8 +: 8] = pwdata[b*8 +: 8];
            end
            if (lane_wr[b] && hit_hhi) begin
                hash_high_next[b*8 +: 8] = pwdata[b*8 +: 8];
            end
            if (lane_wr[b] && hit_slo && rx_stopped) begin
                station_low_next[b*8 +: 8] = pwdata[b*8 +: 8];
            end
        end
        // reserved upper half of the high station word is not stored
        for (int b = 0; b < STATION_LANES; b++) begin
            if (lane_wr[b] && hit_shi && rx_stopped) begin
                station_hi_next[b*8 +: 8] = pwdata[b*8 +: 8];
            end
        end
    end

    // read data captured in setup, held through the access phase
    always_comb begin
        prdata_next = 32'h00000000;
        if (psel && penable) begin
            prdata_next = prdata_reg;
        end else if (rd_setup) begin
            if (hit_hlo) begin
                prdata_next = hash_low_reg;
            end else if (hit_hhi) begin
                prdata_next = hash_high_reg;
            end else if (hit_slo) begin
                prdata_next = station_low_reg;
            end else if (hit_shi) begin
                prdata_next = {16'h0000, station_hi_reg};
            end else if (hit_rxs) begin
                prdata_next = {29'h0, rx_state_sync};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hash_low_reg    <= mhf_pkg::HASH_RESET;
            hash_high_reg   <= mhf_pkg::HASH_RESET;
            station_low_reg <= STATION_LOW_RESET;
            station_hi_reg  <= STATION_HI_RESET;
            prdata_reg      <= 32'h00000000;
        end else begin
            hash_low_reg    <= hash_low_next;
            hash_high_reg   <= hash_high_next;
            station_low_reg <= station_low_next;
            station_hi_reg  <= station_hi_next;
            prdata_reg      <= prdata_next;
        end
    end

    assign prdata       = prdata_reg;

    assign hash_table   = {hash_high_reg, hash_low_reg};
    assign station_addr = {station_hi_reg, station_low_reg};

    // ============================================================
    // assertions
    property p_hash_low_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_hlo && pstrb == 4'hf)
            |=> hash_table[31:0] == $past(pwdata);
    endproperty
    a_hash_low_write: assert property (p_hash_low_write)
        else $error("hash low write not stored");

    property p_hash_high_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_hhi && pstrb == 4'hf)
            |=> hash_table[63:32] == $past(pwdata);
    endproperty
    a_hash_high_write: assert property (p_hash_high_write)
        else $error("hash high write not stored");

    property p_hash_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_hlo) |-> prdata == hash_table[31:0];
    endproperty
    a_hash_read: assert property (p_hash_read)
        else $error("hash low read mismatch");

    property p_hash_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && hit_hhi) |=> $stable(hash_table[63:32]);
    endproperty
    a_hash_hold: assert property (p_hash_hold)
        else $error("hash high changed without write");

    property p_station_lock;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && (hit_slo || hit_shi) && !rx_stopped)
            |=> $stable(station_addr);
    endproperty
    a_station_lock: assert property (p_station_lock)
        else $error("station address written while receiving");

    property p_station_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_slo && rx_stopped && pstrb == 4'hf)
            |=> station_addr[31:0] == $past(pwdata);
    endproperty
    a_station_write: assert property (p_station_write)
        else $error("station low write lost while stopped");

    property p_station_hi_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_shi && rx_stopped && pstrb == 4'hf)
            |=> station_addr[47:32] == $past(pwdata[15:0]);
    endproperty
    a_station_hi_write: assert property (p_station_hi_write)
        else $error("station high write lost while stopped");

    property p_station_hi_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_shi) |-> prdata[31:16] == 16'h0000;
    endproperty
    a_station_hi_rsvd: assert property (p_station_hi_rsvd)
        else $error("reserved station bits not zero");

    property p_lock_follows;
        @(posedge pclk) disable iff (!presetn)
        (rx_state != mhf_pkg::RX_STOPPED) [*3] |-> station_write_lock;
    endproperty
    a_lock_follows: assert property (p_lock_follows)
        else $error("lock not raised while receiving");

    // read path
    property p_hash_high_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_hhi) |-> prdata == hash_table[63:32];
    endproperty
    a_hash_high_read: assert property (p_hash_high_read)
        else $error("hash high read mismatch");

    property p_station_low_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_slo) |-> prdata == station_addr[31:0];
    endproperty
    a_station_low_read: assert property (p_station_low_read)
        else $error("station low read mismatch");

    property p_station_hi_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_shi) |-> prdata[15:0] == station_addr[47:32];
    endproperty
    a_station_hi_read: assert property (p_station_hi_read)
        else $error("station high read mismatch");

    property p_rx_state_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && hit_rxs) |-> prdata == {29'h0, $past(rx_state_sync)};
    endproperty
    a_rx_state_read: assert property (p_rx_state_read)
        else $error("receive state read mismatch");

    property p_unmapped_rdata;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && !mapped) |-> prdata == 32'h00000000;
    endproperty
    a_unmapped_rdata: assert property (p_unmapped_rdata)
        else $error("unmapped read data not zero");

    // write path
    property p_hash_low_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && hit_hlo) |=> $stable(hash_table[31:0]);
    endproperty
    a_hash_low_hold: assert property (p_hash_low_hold)
        else $error("hash low changed without write");

    property p_hash_low_lane_keep;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_hlo && !pstrb[1]) |=> $stable(hash_table[15:8]);
    endproperty
    a_hash_low_lane_keep: assert property (p_hash_low_lane_keep)
        else $error("hash low lane written without strobe");

    property p_hash_high_lane_keep;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_hhi && !pstrb[0]) |=> $stable(hash_table[39:32]);
    endproperty
    a_hash_high_lane_keep: assert property (p_hash_high_lane_keep)
        else $error("hash high lane written without strobe");

    // station protection
    property p_station_low_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && hit_slo) |=> $stable(station_addr[31:0]);
    endproperty
    a_station_low_hold: assert property (p_station_low_hold)
        else $error("station low changed without write");

    property p_lock_release;
        @(posedge pclk) disable iff (!presetn)
        (rx_state == mhf_pkg::RX_STOPPED) [*3] |-> !station_write_lock;
    endproperty
    a_lock_release: assert property (p_lock_release)
        else $error("lock held while receive stopped");

    c_hash_write: cover property (@(posedge pclk) wr_en && hit_hlo);
    c_station_blocked: cover property (@(posedge pclk)
        wr_en && hit_slo && !rx_stopped);
    c_station_ok: cover property (@(posedge pclk)
        wr_en && hit_shi && rx_stopped);
    c_unmapped: cover property (@(posedge pclk) pslverr);
    c_lane_write: cover property (@(posedge pclk)
        wr_en && hit_hhi && pstrb != 4'hf);

endmodule

// >>> mhf_tb.sv
// Purpose: self-checking bench for the hash filter register bank
// Assumes: zero-wait APB slave, receive state synchronised in two flops
// Notes:   station reset values left at their defaults of zero
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h00000000;
    logic [3:0]  pstrb    = 4'h0;
    logic [2:0]  rx_state = 3'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        station_write_lock;
    logic [63:0] hash_table;
    logic [47:0] station_addr;
    logic [31:0] rd;
    logic        er;
    int          n_errors = 0;
    int          checks   = 0;

    always #5 pclk = ~pclk;

    mhf_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_state(rx_state), .hash_table(hash_table),
        .station_addr(station_addr),
        .station_write_lock(station_write_lock)
    );

    // ============================================================
    // helpers
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one APB transfer; read data and error taken at the pready edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       logic [3:0] s);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk("pready", 64'h1, {63'h0, pready});
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let the write land before callers look at stored state
        @(negedge pclk);
    endtask

    task automatic set_rx(logic [2:0] v);
        @(posedge pclk);
        rx_state <= v;
        repeat (3) @(posedge pclk);
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, 8'hac, 32'h0, 4'h0);
        chk("hash low reset", 64'h0, {32'h0, rd});
        chk("mapped rd err", 64'h0, {63'h0, er});
        apb(1'b0, 8'hb0, 32'h0, 4'h0);
        chk("hash high reset", 64'h0, {32'h0, rd});
        chk("hash table reset", 64'h0, hash_table);
    endtask

    task automatic t_hash();
        apb(1'b1, 8'hac, 32'h44332211, 4'hf);
        apb(1'b1, 8'hb0, 32'h88776655, 4'hf);
        chk("table low", 64'h44332211, {32'h0, hash_table[31:0]});
        chk("table high", 64'h88776655, {32'h0, hash_table[63:32]});
        apb(1'b1, 8'hac, 32'haabbccdd, 4'h5);
        apb(1'b0, 8'hac, 32'h0, 4'h0);
        chk("hash low lanes", 64'h44bb22dd, {32'h0, rd});
        apb(1'b1, 8'hb0, 32'h01020304, 4'ha);
        apb(1'b0, 8'hb0, 32'h0, 4'h0);
        chk("hash high lanes", 64'h01770355, {32'h0, rd});
    endtask

    task automatic t_station();
        set_rx(3'h0);
        apb(1'b1, 8'ha4, 32'h11e80000, 4'hf);
        apb(1'b1, 8'ha8, 32'hffff3322, 4'hf);
        apb(1'b0, 8'ha8, 32'h0, 4'h0);
        chk("station high read", 64'h3322, {32'h0, rd});
        chk("station addr", 64'h332211e80000, {16'h0, station_addr});
    endtask

    task automatic t_locked();
        set_rx(3'h3);
        chk("lock set", 64'h1, {63'h0, station_write_lock});
        apb(1'b0, 8'hb4, 32'h0, 4'h0);
        chk("rx state read", 64'h3, {32'h0, rd});
        apb(1'b1, 8'ha4, 32'hdeadbeef, 4'hf);
        apb(1'b1, 8'ha8, 32'h0000abcd, 4'hf);
        chk("station kept", 64'h332211e80000, {16'h0, station_addr});
        apb(1'b0, 8'ha4, 32'h0, 4'h0);
        chk("station low read", 64'h11e80000, {32'h0, rd});
        set_rx(3'h0);
        chk("lock clear", 64'h0, {63'h0, station_write_lock});
        apb(1'b1, 8'ha8, 32'h00005544, 4'h3);
        chk("station byte4", 64'h44, {56'h0, station_addr[39:32]});
        chk("station byte5", 64'h55, {56'h0, station_addr[47:40]});
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h10, 32'hffffffff, 4'hf);
        chk("unmapped wr err", 64'h1, {63'h0, er});
        apb(1'b0, 8'h10, 32'h0, 4'h0);
        chk("unmapped rd err", 64'h1, {63'h0, er});
        chk("unmapped rd data", 64'h0, {32'h0, rd});
        chk("table untouched", 64'h0177035544bb22dd, hash_table);
    endtask

    // ============================================================
    // run control
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_hash();
        t_station();
        t_locked();
        t_unmapped();
        print_verdict();
    end
endmodule
